/* tcc_pkg.sv */
/*
 * Constants shared by the timer capture/compare block: register byte
 * offsets, field positions and reset values.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`default_nettype none
package tcc_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_EDGE_SEL   = 8'h00;
    localparam logic [7:0] OFS_SET_EN     = 8'h04;
    localparam logic [7:0] OFS_CLR_TGL_EN = 8'h08;
    localparam logic [7:0] OFS_FLAGS      = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h10;
    localparam logic [7:0] OFS_CMP0       = 8'h14;
    localparam logic [7:0] OFS_CMP1       = 8'h18;
    localparam logic [7:0] OFS_CMP2       = 8'h1c;
    localparam logic [7:0] OFS_CAP0       = 8'h20;
    localparam logic [7:0] OFS_CAP1       = 8'h24;
    localparam logic [7:0] OFS_CAP2       = 8'h28;
    localparam logic [7:0] OFS_CAP3       = 8'h2c;
    localparam logic [7:0] OFS_PORT       = 8'h30;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int NUM_CAP        = 4;
    localparam int NUM_CMP        = 3;
    localparam int TIMER_W        = 16;
    localparam int FLAG_W         = 7;
    localparam int FLAG_CMP_LO    = 4;
    localparam int PORT_W         = 8;
    localparam int SETCLR_W       = 6;
    localparam int TOGGLE_PIN6    = 6;
    localparam int TOGGLE_PIN7    = 7;
    localparam int CMP_SET        = 0;
    localparam int CMP_CLEAR      = 1;
    localparam int CMP_TOGGLE     = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [6:0]  RST_FLAGS = 7'h00;
    localparam logic [31:0] BUS_ZERO  = 32'h0000_0000;
endpackage
`default_nettype wire

/* tcc_capture_compare.sv */
/*
 * Capture and compare unit beside a 16-bit general timer: four edge
 * capture channels, three compare channels driving an 8-bit output port,
 * sticky event flags with enables and one level interrupt.
 * Assumes the timer runs elsewhere and presents its new value together
 * with a one-cycle increment strobe; capture inputs are synchronous.
 */
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Odd edge-select bit enables falling-edge capture
// [RULE2] Even bit enables rising; both give either edge
// [RULE3] Compare new timer value on each increment
// [RULE4] Match sets compare flag next cycle (here two cycles later, as matchHit is registered)
// [RULE5] Compare flag interrupts only when enabled
// [RULE6] Compare 0 match sets enabled port bits 0-5
// [RULE7] Compare 1 match clears enabled port bits 0-5
// [RULE8] Compare 2 match toggles enabled pins 7, 6
// [RULE9] Toggle hits dedicated flops, not port latch
// [RULE10] Zero enable bit disables that pin's action
// [RULE11] Qualifying edge loads timer into capture register
// [RULE12] Capture edge sets flag, interrupts if enabled
// [RULE13] Edge selection governs capture and interrupt alike
// [RULE14] Flags stay set until software writes zero
module tcc_capture_compare #(
    parameter int TIMER_W = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [TIMER_W-1:0] timerValue,
    input  wire logic               timerInc,
    input  wire logic [3:0]         captureIn,
    output logic      [7:0]         compareOutputPort,
    output logic                    irq
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]         captureEdgeSelect;
    logic [5:0]         setEnable;
    logic               toggleFlopLow;
    logic               toggleFlopHigh;
    logic [7:0]         compareClearToggleEnable;
    logic [6:0]         timerEventFlags;
    logic [6:0]         extendedIrqEnables;
    logic [TIMER_W-1:0] compareValue [tcc_pkg::NUM_CMP];
    logic [TIMER_W-1:0] captureValue [tcc_pkg::NUM_CAP];
    logic [5:0]         portLatch;
    logic [3:0]         capturePrev;
    logic [2:0]         matchHit;

    logic               busReq;
    logic               wrEn;
    logic [3:0]         captureHit;
    logic [2:0]         compareNow;
    logic [31:0]        next_readData;

    assign busReq = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign wrEn   = busReq & wb_we_i & wb_ack_o;

    function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] val,
                                             input logic sel);
        mergeByte = sel ? val : old;
    endfunction

    // ------------------------------------------------------------------
    // Capture edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            capturePrev <= 4'h0;
        end else begin
            capturePrev <= captureIn;
        end
    end

    always_comb begin
        captureHit = 4'h0;
        for (int ch = 0; ch < tcc_pkg::NUM_CAP; ch++) begin
            // [RULE13] One qualifier for both uses
            // [RULE1] Falling edge enable
            // [RULE2] Rising edge enable
            captureHit[ch] = (captureEdgeSelect[2*ch+1] & capturePrev[ch] & ~captureIn[ch])
                           | (captureEdgeSelect[2*ch] & ~capturePrev[ch] & captureIn[ch]);
        end
    end

    // [RULE11] Latch timer on qualifying edge
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int ch = 0; ch < tcc_pkg::NUM_CAP; ch++) begin
                captureValue[ch] <= '0;
            end
        end else begin
            for (int ch = 0; ch < tcc_pkg::NUM_CAP; ch++) begin
                if (captureHit[ch]) begin
                    captureValue[ch] <= timerValue;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------------
    always_comb begin
        compareNow = 3'h0;
        for (int ch = 0; ch < tcc_pkg::NUM_CMP; ch++) begin
            // [RULE3] Checked only on an increment
            compareNow[ch] = timerInc & (timerValue == compareValue[ch]);
        end
    end

    // Match is registered so flag and pins act one cycle later
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            matchHit <= 3'h0;
        end else begin
            matchHit <= compareNow;
        end
    end

    // ------------------------------------------------------------------
    // Event flags and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timerEventFlags <= tcc_pkg::RST_FLAGS;
        end else begin
            // [RULE14] Cleared only by writing zero; set wins
            // [RULE4] Flag set two cycles after the match, via registered matchHit
            // [RULE12] Capture edge sets its flag
            timerEventFlags <= (wrEn && wb_adr_i == tcc_pkg::OFS_FLAGS && wb_sel_i[0]
                               ? timerEventFlags & wb_dat_i[6:0] : timerEventFlags)
                             | {matchHit, captureHit};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            // [RULE5] Compare flags gated by enables
            // [RULE12] Capture flags gated by enables
            irq <= |(timerEventFlags & extendedIrqEnables);
        end
    end

    // ------------------------------------------------------------------
    // Output port
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            portLatch <= 6'h00;
        end else begin
            // [RULE6] Set enabled bits on compare 0
            // [RULE7] Clear enabled bits on compare 1
            // [RULE10] Zero enable leaves pin alone
            // Clear applied after set, so it wins on a joint match
            portLatch <= ((wrEn && wb_adr_i == tcc_pkg::OFS_PORT && wb_sel_i[0])
                         ? wb_dat_i[5:0] : portLatch)
                       | ({6{matchHit[tcc_pkg::CMP_SET]}} & setEnable);
            if (matchHit[tcc_pkg::CMP_CLEAR]) begin
                portLatch <= (((wrEn && wb_adr_i == tcc_pkg::OFS_PORT && wb_sel_i[0])
                             ? wb_dat_i[5:0] : portLatch)
                           | ({6{matchHit[tcc_pkg::CMP_SET]}} & setEnable))
                           & ~compareClearToggleEnable[5:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggleFlopLow  <= 1'b0;
            toggleFlopHigh <= 1'b0;
        end else if (matchHit[tcc_pkg::CMP_TOGGLE]) begin
            // [RULE8] Toggle pins 7 and 6 when enabled
            // [RULE9] Dedicated flops, port latch untouched
            toggleFlopLow  <= toggleFlopLow ^ compareClearToggleEnable[tcc_pkg::TOGGLE_PIN6];
            toggleFlopHigh <= toggleFlopHigh ^ compareClearToggleEnable[tcc_pkg::TOGGLE_PIN7];
        end else if (wrEn && wb_adr_i == tcc_pkg::OFS_SET_EN && wb_sel_i[0]) begin
            toggleFlopLow  <= wb_dat_i[tcc_pkg::TOGGLE_PIN6];
            toggleFlopHigh <= wb_dat_i[tcc_pkg::TOGGLE_PIN7];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            compareOutputPort <= tcc_pkg::RST_BYTE;
        end else begin
            compareOutputPort <= {toggleFlopHigh, toggleFlopLow, portLatch};
        end
    end

    // ------------------------------------------------------------------
    // Software-written configuration
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            captureEdgeSelect        <= tcc_pkg::RST_BYTE;
            setEnable                <= 6'h00;
            compareClearToggleEnable <= tcc_pkg::RST_BYTE;
            extendedIrqEnables       <= tcc_pkg::RST_FLAGS;
            for (int ch = 0; ch < tcc_pkg::NUM_CMP; ch++) begin
                compareValue[ch] <= '0;
            end
        end else if (wrEn) begin
            unique case (wb_adr_i)
                tcc_pkg::OFS_EDGE_SEL: begin
                    captureEdgeSelect <= mergeByte(captureEdgeSelect, wb_dat_i[7:0], wb_sel_i[0]);
                end
                tcc_pkg::OFS_SET_EN: begin
                    if (wb_sel_i[0]) begin
                        setEnable <= wb_dat_i[5:0];
                    end
                end
                tcc_pkg::OFS_CLR_TGL_EN: begin
                    compareClearToggleEnable <= mergeByte(compareClearToggleEnable,
                                                          wb_dat_i[7:0], wb_sel_i[0]);
                end
                tcc_pkg::OFS_IRQ_EN: begin
                    if (wb_sel_i[0]) begin
                        extendedIrqEnables <= wb_dat_i[6:0];
                    end
                end
                tcc_pkg::OFS_CMP0, tcc_pkg::OFS_CMP1, tcc_pkg::OFS_CMP2: begin
                    for (int ch = 0; ch < tcc_pkg::NUM_CMP; ch++) begin
                        if (wb_adr_i == tcc_pkg::OFS_CMP0 + 8'(4 * ch)) begin
                            compareValue[ch] <= {mergeByte(compareValue[ch][15:8],
                                                           wb_dat_i[15:8], wb_sel_i[1]),
                                                 mergeByte(compareValue[ch][7:0],
                                                           wb_dat_i[7:0], wb_sel_i[0])};
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Wishbone read and acknowledge
    // ------------------------------------------------------------------
    always_comb begin
        next_readData = tcc_pkg::BUS_ZERO;
        unique case (wb_adr_i)
            tcc_pkg::OFS_EDGE_SEL:   next_readData[7:0]  = captureEdgeSelect;
            tcc_pkg::OFS_SET_EN:     next_readData[7:0]  = {toggleFlopHigh, toggleFlopLow,
                                                            setEnable};
            tcc_pkg::OFS_CLR_TGL_EN: next_readData[7:0]  = compareClearToggleEnable;
            tcc_pkg::OFS_FLAGS:      next_readData[6:0]  = timerEventFlags;
            tcc_pkg::OFS_IRQ_EN:     next_readData[6:0]  = extendedIrqEnables;
            tcc_pkg::OFS_CMP0:       next_readData[15:0] = compareValue[0];
            tcc_pkg::OFS_CMP1:       next_readData[15:0] = compareValue[1];
            tcc_pkg::OFS_CMP2:       next_readData[15:0] = compareValue[2];
            tcc_pkg::OFS_CAP0:       next_readData[15:0] = captureValue[0];
            tcc_pkg::OFS_CAP1:       next_readData[15:0] = captureValue[1];
            tcc_pkg::OFS_CAP2:       next_readData[15:0] = captureValue[2];
            tcc_pkg::OFS_CAP3:       next_readData[15:0] = captureValue[3];
            tcc_pkg::OFS_PORT:       next_readData[7:0]  = compareOutputPort;
            default:                 next_readData       = tcc_pkg::BUS_ZERO;
        endcase
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= tcc_pkg::BUS_ZERO;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= next_readData;
            end
        end
    end
endmodule
`default_nettype wire

/* tcc_pin_model.sv */
/* Far-side model of the four capture input pins: toggles a pin on request.
   Assumes one-cycle requests; a slow request lags three cycles. */
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] edgeReq,
    input  wire logic       slow,
    output logic      [3:0] captureIn
);
    logic [3:0] pend;
    logic [1:0] dly;
    // Pins move just after an edge, as a synchronous source would
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {captureIn, pend, dly} <= '0;
        end else if (|edgeReq) begin
            {pend, dly} <= {edgeReq, slow ? 2'h3 : 2'h0};
        end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
        end else begin
            {captureIn, pend} <= {captureIn ^ pend, 4'h0};
        end
    end
endmodule
`default_nettype wire

/* tcc_capture_compare_checker.sv */
/* Port-level assertions for tcc_capture_compare.
   Assumes a classic Wishbone master and a one-cycle timer increment strobe. */
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_compare_checker #(
    parameter int TIMER_W = 16
) (
    input wire logic               ref_clk,
    input wire logic               reset_n,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire logic [TIMER_W-1:0] timerValue,
    input wire logic               timerInc,
    input wire logic [3:0]         captureIn,
    input wire logic [7:0]         compareOutputPort,
    input wire logic               irq
);
    logic        wrAck;
    logic [2:0]  incH, wrH;
    logic [11:0] capH;
    assign wrAck = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    // Short histories of the causes, so effects can be traced back
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) {incH, wrH, capH} <= '0;
        else {incH, wrH, capH} <= {incH[1:0], timerInc, wrH[1:0], wrAck, capH[7:0], captureIn};
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence sReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence sIdle; !wb_cyc_i ##1 !wb_cyc_i; endsequence
    a_ack_follows_req: assert property (sReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_idle_no_ack: assert property (sIdle |-> !wb_ack_o)
        else $error("ack while bus idle");
    a_rdata_holds: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data changed outside a read");
    a_port_low_cause: assert property ($changed(compareOutputPort[5:0]) |-> incH[2] || |wrH)
        else $error("port bits 5:0 changed without match or write");
    a_toggle_cause: assert property ($changed(compareOutputPort[7:6]) |-> incH[2] || |wrH)
        else $error("toggle outputs changed without match or write");
    a_irq_rise_cause: assert property ($rose(irq) |-> incH[2] || capH[7:4] != capH[11:8] || |wrH)
        else $error("irq rose without event or write");
    a_irq_sticky: assert property ($fell(irq) |-> |wrH)
        else $error("irq fell without a register write");
endmodule
`default_nettype wire

/* tcc_capture_compare_tb.sv */
/* Self-checking bench for tcc_capture_compare: bus, capture and compare tests.
   Assumes tcc_pkg, the pin model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_compare_tb;
    logic        ref_clk, reset_n, cyc, stb, we, ack, tInc, irq, slow;
    logic [7:0]  adr, port, outPort, s, r, e, pw;
    logic [31:0] wdat, rdat, dOut;
    logic [15:0] tVal, a, r1, r2;
    logic [15:0] old [4];
    logic [3:0]  capIn, eReq;
    int          errCount, nCompared, cycN;

    tcc_capture_compare #(.TIMER_W(16)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dOut), .wb_ack_o(ack), .timerValue(tVal), .timerInc(tInc),
        .captureIn(capIn), .compareOutputPort(outPort), .irq(irq));
    tcc_pin_model pins_u (.ref_clk(ref_clk), .reset_n(reset_n), .edgeReq(eReq),
        .slow(slow), .captureIn(capIn));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] expPort(logic [7:0] p, sv, rv, int k);
        if (k == 0) return {p[7:6], p[5:0] | sv[5:0]};
        if (k == 1) return {p[7:6], p[5:0] & ~rv[5:0]};
        return {p[7:6] ^ rv[7:6], p[5:0]};
    endfunction
    function automatic logic [15:0] expCap(logic [1:0] m, logic [15:0] o, v1, v2);
        return m[1] ? v2 : (m[0] ? v1 : o);
    endfunction
    task automatic endOfTest();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ev, gv);
        nCompared++;
        if (gv !== ev) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, ev, gv);
        end
    endtask
    // Holds the request until ack is sampled, then idles one cycle
    // No local limit: only the cycle ceiling below ends a stuck wait
    task automatic wbDo(input logic w, input logic [7:0] ad, input logic [31:0] v);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, ad, v};
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rdat = dOut;
        {cyc, stb, we} <= 3'b000;
        @(posedge ref_clk);
    endtask
    task automatic bump(input logic [15:0] v, input logic inc);
        {tVal, tInc} <= {v, inc};
        @(posedge ref_clk);
        tInc <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic pin(input logic [3:0] m);
        {eReq, slow} <= {m, 1'($urandom)};
        @(posedge ref_clk);
        eReq <= 4'h0;
        repeat (8) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycN++;
        if (cycN > 5000) begin
            errCount++;
            endOfTest();
        end
    end
    initial begin
        {reset_n, cyc, stb, we, adr, wdat, tVal, tInc, eReq, slow} = '0;
        old = '{default: 16'h0000};
        void'($urandom(32'hacf8));
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i <= 16; i++) begin
            wbDo(1'b0, 8'(i * 4), '0);
            chk("reset value", '0, rdat);
        end
        wbDo(1'b1, 8'h40, '1);
        wbDo(1'b0, 8'h40, '0);
        chk("unmapped read", '0, rdat);
        $display("test reset done");
        for (int ch = 0; ch < 4; ch++) begin
            for (int m = 0; m < 4; m++) begin
                wbDo(1'b1, tcc_pkg::OFS_EDGE_SEL, 32'(m << (2 * ch)));
                wbDo(1'b1, tcc_pkg::OFS_IRQ_EN, 32'(1 << ch));
                {r1, r2} = 32'($urandom);
                tVal <= r1;
                pin(4'(1 << ch));
                tVal <= r2;
                pin(4'(1 << ch));
                old[ch] = expCap(2'(m), old[ch], r1, r2);
                wbDo(1'b0, 8'(tcc_pkg::OFS_CAP0 + 4 * ch), '0);
                chk("capture value", 32'(old[ch]), rdat);
                wbDo(1'b0, tcc_pkg::OFS_FLAGS, '0);
                chk("capture flag", 32'(m != 0) << ch, rdat);
                chk("capture irq", 32'(m != 0), 32'(irq));
                wbDo(1'b1, tcc_pkg::OFS_FLAGS, '0);
                @(posedge ref_clk);
                chk("irq cleared", '0, 32'(irq));
            end
        end
        $display("test capture done");
        for (int it = 0; it < 4; it++) begin
            {a, s, r} = 32'($urandom);
            {e, pw} = 16'($urandom);
            wbDo(1'b1, tcc_pkg::OFS_SET_EN, 32'(s));
            wbDo(1'b1, tcc_pkg::OFS_CLR_TGL_EN, 32'(r));
            wbDo(1'b1, tcc_pkg::OFS_IRQ_EN, 32'(e));
            wbDo(1'b1, tcc_pkg::OFS_PORT, 32'(pw));
            for (int k = 0; k < 3; k++) wbDo(1'b1, 8'(tcc_pkg::OFS_CMP0 + 4 * k), 32'(16'(a + k)));
            port = {s[7:6], pw[5:0]};
            bump(a, 1'b0);
            chk("port without increment", 32'(port), 32'(outPort));
            for (int k = 0; k < 3; k++) begin
                bump(16'(a + k), 1'b1);
                port = expPort(port, s, r, k);
                chk("compare port", 32'(port), 32'(outPort));
            end
            wbDo(1'b0, tcc_pkg::OFS_SET_EN, '0);
            chk("toggle flops", 32'({port[7:6], s[5:0]}), rdat);
            wbDo(1'b0, tcc_pkg::OFS_FLAGS, '0);
            chk("compare flags", 32'h0000_0070, rdat);
            chk("compare irq", 32'(|e[6:4]), 32'(irq));
            wbDo(1'b1, tcc_pkg::OFS_FLAGS, '0);
        end
        $display("test compare done");
        endOfTest();
    end
endmodule
bind tcc_capture_compare tcc_capture_compare_checker #(.TIMER_W(TIMER_W)) chk_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timerValue(timerValue),
    .timerInc(timerInc), .captureIn(captureIn), .compareOutputPort(compareOutputPort),
    .irq(irq));
`default_nettype wire
